// File: hdl/tmh_pkg.sv
// constants shared by the split 16-bit timer and its halves
// assumes a single 100 MHz system clock and an AXI4-Lite host
package tmh_pkg;

    // register byte offsets
    localparam logic [7:0] TMH_OFS_CFG     = 8'h00;
    localparam logic [7:0] TMH_OFS_MODE_A  = 8'h04;
    localparam logic [7:0] TMH_OFS_MODE_B  = 8'h08;
    localparam logic [7:0] TMH_OFS_CTL     = 8'h0c;
    localparam logic [7:0] TMH_OFS_IMR     = 8'h18;
    localparam logic [7:0] TMH_OFS_RIS     = 8'h1c;
    localparam logic [7:0] TMH_OFS_MIS     = 8'h20;
    localparam logic [7:0] TMH_OFS_ICR     = 8'h24;
    localparam logic [7:0] TMH_OFS_ILR_A   = 8'h28;
    localparam logic [7:0] TMH_OFS_ILR_B   = 8'h2c;
    localparam logic [7:0] TMH_OFS_MATCH_A = 8'h30;
    localparam logic [7:0] TMH_OFS_MATCH_B = 8'h34;
    localparam logic [7:0] TMH_OFS_PR_A    = 8'h38;
    localparam logic [7:0] TMH_OFS_PR_B    = 8'h3c;
    localparam logic [7:0] TMH_OFS_TV_A    = 8'h48;
    localparam logic [7:0] TMH_OFS_TV_B    = 8'h4c;

    // global configuration value for two 16-bit halves
    localparam logic [2:0] TMH_CFG_SPLIT = 3'h4;

    // half mode register fields
    localparam int TMH_MR_LSB  = 0;
    localparam int TMH_CMR_BIT = 2;
    localparam int TMH_AMS_BIT = 3;
    localparam logic [1:0] TMH_MR_ONESHOT  = 2'h1;
    localparam logic [1:0] TMH_MR_PERIODIC = 2'h2;
    localparam logic [1:0] TMH_MR_CAPTURE  = 2'h3;

    // control register fields, second half sits one stride higher
    localparam int TMH_CTL_STRIDE  = 8;
    localparam int TMH_CTL_EN      = 0;
    localparam int TMH_CTL_STALL   = 1;
    localparam int TMH_CTL_EVT_LSB = 2;
    localparam int TMH_CTL_OTE     = 5;
    localparam int TMH_CTL_INV     = 6;

    // event field encodings; any other code counts both edges
    localparam logic [1:0] TMH_EV_RISE = 2'h0;
    localparam logic [1:0] TMH_EV_FALL = 2'h1;

    // status bit positions, second half one stride higher
    localparam int TMH_ST_STRIDE = 8;
    localparam int TMH_ST_TO     = 0;
    localparam int TMH_ST_MATCH  = 1;
    localparam int TMH_ST_CAP    = 2;

    // values after reset
    localparam logic [15:0] TMH_CNT_RST = 16'hffff;
    localparam logic [15:0] TMH_ILR_RST = 16'hffff;
    localparam logic [7:0]  TMH_PR_RST  = 8'h00;

    // bus answers
    localparam logic [1:0] TMH_RESP_OKAY   = 2'h0;
    localparam logic [1:0] TMH_RESP_SLVERR = 2'h2;

endpackage

// File: hdl/tmh_half.sv
// one 16-bit timer half: one-shot, periodic, edge count, edge time, pwm
// assumes the register file in the parent holds all settings
`timescale 1ns/100ps
module tmh_half
    import tmh_pkg::*;
(
    // clock and reset
    input  wire logic        sys_clk,
    input  wire logic        resetn,
    // settings
    input  wire logic        enable,
    input  wire logic [1:0]  mode_field,
    input  wire logic        capture_mode,
    input  wire logic        alt_mode,
    input  wire logic [1:0]  event_sel,
    input  wire logic        stall,
    input  wire logic        trig_en,
    input  wire logic        invert,
    input  wire logic [15:0] load_val,
    input  wire logic        load_wr,
    input  wire logic [15:0] match_val,
    input  wire logic [7:0]  prescale,
    input  wire logic        dbg_halted,
    // pin
    input  wire logic        pin_in,
    output logic             pin_out,
    output logic             pin_oe_n,
    // results
    output logic [15:0]      count,
    output logic [15:0]      captured,
    output logic             timeout_evt,
    output logic             match_evt,
    output logic             capture_evt,
    output logic             trig,
    output logic             en_clr
);

    typedef struct packed {
        logic [2:0]  sync;
        logic        lvl;
        logic [15:0] cnt;
        logic [7:0]  pre;
        logic [15:0] cap;
        logic        pwm_raw;
        logic        pwm_pin;
        logic        oe_n;
        logic        timeout;
        logic        match;
        logic        capture;
        logic        trig;
        logic        en_clr;
    } tmh_half_state_t;

    tmh_half_state_t s;
    tmh_half_state_t next_s;

    logic edge_seen;
    logic ev;
    logic run;
    logic pwm_mode;
    logic time_mode;
    logic cnt_mode;
    logic oneshot;
    logic periodic;
    logic at_zero;

    assign pwm_mode  = alt_mode & ~capture_mode
                       & (mode_field == TMH_MR_PERIODIC);
    assign time_mode = capture_mode & (mode_field == TMH_MR_CAPTURE);
    assign cnt_mode  = ~capture_mode & (mode_field == TMH_MR_CAPTURE);
    assign oneshot   = (mode_field == TMH_MR_ONESHOT);
    assign periodic  = ~alt_mode & (mode_field == TMH_MR_PERIODIC);
    assign at_zero   = (s.cnt == 16'h0000);

    // the pulse guard keeps a self-disabled half from ticking once more
    assign run = enable & ~s.en_clr & ~(stall & dbg_halted);

    // only the agreed second and third stages decide a new level
    assign edge_seen = (s.sync[1] == s.sync[2]) && (s.sync[2] != s.lvl);
    always_comb
    begin
        unique case (event_sel)
            TMH_EV_RISE: ev = edge_seen & s.sync[2];
            TMH_EV_FALL: ev = edge_seen & ~s.sync[2];
            default:     ev = edge_seen;
        endcase
    end

    always_comb
    begin
        next_s = s;
        next_s.sync = {s.sync[1:0], pin_in};
        next_s.timeout = 1'b0;
        next_s.match = 1'b0;
        next_s.capture = 1'b0;
        next_s.trig = 1'b0;
        next_s.en_clr = 1'b0;
        if (edge_seen)
        begin
            next_s.lvl = s.sync[2];
        end
        if (load_wr)
        begin
            // new interval taken at once, even mid-count
            next_s.cnt = load_val;
            next_s.pre = prescale;
        end
        else if (run)
        begin
            if (pwm_mode || time_mode)
            begin
                // prescaler bypassed, one step per clock
                next_s.cnt = at_zero ? load_val : s.cnt - 16'h0001;
                if (time_mode && ev)
                begin
                    next_s.cap = s.cnt;
                    next_s.capture = 1'b1;
                end
            end
            else if (cnt_mode)
            begin
                if (ev)
                begin
                    if ((s.cnt - 16'h0001) == match_val)
                    begin
                        next_s.match = 1'b1;
                        next_s.cnt = load_val;
                        next_s.en_clr = 1'b1;
                    end
                    else
                    begin
                        next_s.cnt = s.cnt - 16'h0001;
                    end
                end
            end
            else if (oneshot || periodic)
            begin
                if (s.pre != 8'h00)
                begin
                    next_s.pre = s.pre - 8'h01;
                end
                else
                begin
                    next_s.pre = prescale;
                    if (at_zero)
                    begin
                        next_s.cnt = load_val;
                        next_s.timeout = 1'b1;
                        next_s.trig = trig_en;
                        next_s.en_clr = oneshot;
                    end
                    else
                    begin
                        next_s.cnt = s.cnt - 16'h0001;
                    end
                end
            end
        end
        if (pwm_mode)
        begin
            if (s.cnt == load_val)
            begin
                next_s.pwm_raw = 1'b1;
            end
            else if (s.cnt == match_val)
            begin
                next_s.pwm_raw = 1'b0;
            end
        end
        next_s.pwm_pin = next_s.pwm_raw ^ invert;
        next_s.oe_n = ~pwm_mode;
    end

    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            s <= '{sync: 3'h0, lvl: 1'b0, cnt: TMH_CNT_RST,
                   pre: TMH_PR_RST, cap: TMH_CNT_RST, pwm_raw: 1'b0,
                   pwm_pin: 1'b0, oe_n: 1'b1, timeout: 1'b0,
                   match: 1'b0, capture: 1'b0, trig: 1'b0,
                   en_clr: 1'b0};
        end
        else
        begin
            s <= next_s;
        end
    end

    assign pin_out     = s.pwm_pin;
    assign pin_oe_n    = s.oe_n;
    assign count       = s.cnt;
    assign captured    = s.cap;
    assign timeout_evt = s.timeout;
    assign match_evt   = s.match;
    assign capture_evt = s.capture;
    assign trig        = s.trig;
    assign en_clr      = s.en_clr;

endmodule

// File: hdl/tmh_timer.sv
// Summary of operation
// - config value 4 splits into two halves
// - each half has its own mode register
// - down-counter plus optional 8-bit prescaler
// - mode field picks one-shot or periodic
// - count down, reload at zero next cycle
// - one-shot stops and clears enable; periodic continues
// - time-out sets sticky raw and masked status
// - converter trigger at time-out when enabled
// - interval load write reloads counter next cycle
// - debug stall freezes counter while halted
// - prescale P gives one step per P+1
// - prescaler bypassed in edge and pwm modes
// - capture bit 0 selects edge counting
// - qualifying edges decrement; match sets status
// - after match reload, disable, ignore edges
// - capture bit 1 selects free-running edge time
// - edge copies count to value register
// - edge time keeps counting, reloads at zero
// - pwm when alternate 1, capture 0, mode 2
// - pwm repeats, sets no status
// - pwm high at load value, low at match
// - inversion bit flips pwm polarity
// - mode field 1 one-shot, 2 periodic
// - mode 3 with capture bit 1 times edges
// - writing one to clear register clears flags
//
// top of the split timer: AXI4-Lite register file and two halves
// assumes host obeys AXI4-Lite and one write, one read in flight
`timescale 1ns/100ps
module tmh_timer
    import tmh_pkg::*;
(
    // clock and reset
    input  wire logic        sys_clk,
    input  wire logic        resetn,
    // axi4-lite write address
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    // axi4-lite write data
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    // axi4-lite write response
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // axi4-lite read address
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    // axi4-lite read data
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // debug
    input  wire logic        dbg_halted,
    // capture / compare / pwm pins, index 0 is the first half
    input  wire logic [1:0]  capture_compare_pin_in,
    output logic [1:0]       capture_compare_pin_out,
    output logic [1:0]       capture_compare_pin_oe_n,
    // events
    output logic [1:0]       adc_trig,
    output logic             irq
);

    typedef struct packed {
        logic [2:0]        cfg;
        logic [1:0][3:0]   mode;
        logic [15:0]       ctl;
        logic [15:0]       imr;
        logic [15:0]       ris;
        logic [1:0][15:0]  ilr;
        logic [1:0][15:0]  match;
        logic [1:0][7:0]   pr;
        logic [1:0]        ilr_wr;
        logic              irq;
        logic              awready;
        logic              aw_held;
        logic [7:0]        awaddr;
        logic              wready;
        logic              w_held;
        logic [31:0]       wdata;
        logic [3:0]        wstrb;
        logic              bvalid;
        logic [1:0]        bresp;
        logic              arready;
        logic              rvalid;
        logic [1:0]        rresp;
        logic [31:0]       rdata;
    } tmh_top_state_t;

    tmh_top_state_t s;
    tmh_top_state_t next_s;

    logic [1:0][15:0] h_count;
    logic [1:0][15:0] h_cap;
    logic [1:0]       h_to;
    logic [1:0]       h_match;
    logic [1:0]       h_capt;
    logic [1:0]       h_trig;
    logic [1:0]       h_en_clr;
    logic [15:0]      st_set;
    logic [15:0]      icr_clr;
    logic [31:0]      wmask;
    logic [31:0]      rd_val;
    logic             rd_ok;
    logic             split;

    assign split = (s.cfg == TMH_CFG_SPLIT);

    // identical halves, one instance each
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++)
        begin : g_half
            tmh_half u_half
            (
                .sys_clk      (sys_clk),
                .resetn       (resetn),
                .enable       (split & s.ctl[gi*TMH_CTL_STRIDE+TMH_CTL_EN]),
                .mode_field   (s.mode[gi][TMH_MR_LSB+:2]),
                .capture_mode (s.mode[gi][TMH_CMR_BIT]),
                .alt_mode     (s.mode[gi][TMH_AMS_BIT]),
                .event_sel    (s.ctl[gi*TMH_CTL_STRIDE+TMH_CTL_EVT_LSB+:2]),
                .stall        (s.ctl[gi*TMH_CTL_STRIDE+TMH_CTL_STALL]),
                .trig_en      (s.ctl[gi*TMH_CTL_STRIDE+TMH_CTL_OTE]),
                .invert       (s.ctl[gi*TMH_CTL_STRIDE+TMH_CTL_INV]),
                .load_val     (s.ilr[gi]),
                .load_wr      (s.ilr_wr[gi]),
                .match_val    (s.match[gi]),
                .prescale     (s.pr[gi]),
                .dbg_halted   (dbg_halted),
                .pin_in       (capture_compare_pin_in[gi]),
                .pin_out      (capture_compare_pin_out[gi]),
                .pin_oe_n     (capture_compare_pin_oe_n[gi]),
                .count        (h_count[gi]),
                .captured     (h_cap[gi]),
                .timeout_evt  (h_to[gi]),
                .match_evt    (h_match[gi]),
                .capture_evt  (h_capt[gi]),
                .trig         (h_trig[gi]),
                .en_clr       (h_en_clr[gi])
            );
            // pwm mode never raises status since the half gives no events
            assign st_set[gi*TMH_ST_STRIDE+TMH_ST_TO]    = h_to[gi];
            assign st_set[gi*TMH_ST_STRIDE+TMH_ST_MATCH] = h_match[gi];
            assign st_set[gi*TMH_ST_STRIDE+TMH_ST_CAP]   = h_capt[gi];
            assign st_set[gi*TMH_ST_STRIDE+7:gi*TMH_ST_STRIDE+3] = 5'h00;
        end
    endgenerate

    assign wmask = {{8{s.wstrb[3]}}, {8{s.wstrb[2]}},
                    {8{s.wstrb[1]}}, {8{s.wstrb[0]}}};

    // read decode; edge time mode shows the captured count
    always_comb
    begin
        rd_val = 32'h0000_0000;
        rd_ok = 1'b1;
        unique case (s_axi_araddr)
            TMH_OFS_CFG:     rd_val = {29'h0, s.cfg};
            TMH_OFS_MODE_A:  rd_val = {28'h0, s.mode[0]};
            TMH_OFS_MODE_B:  rd_val = {28'h0, s.mode[1]};
            TMH_OFS_CTL:     rd_val = {16'h0, s.ctl};
            TMH_OFS_IMR:     rd_val = {16'h0, s.imr};
            TMH_OFS_RIS:     rd_val = {16'h0, s.ris};
            TMH_OFS_MIS:     rd_val = {16'h0, s.ris & s.imr};
            TMH_OFS_ICR:     rd_val = 32'h0000_0000;
            TMH_OFS_ILR_A:   rd_val = {16'h0, s.ilr[0]};
            TMH_OFS_ILR_B:   rd_val = {16'h0, s.ilr[1]};
            TMH_OFS_MATCH_A: rd_val = {16'h0, s.match[0]};
            TMH_OFS_MATCH_B: rd_val = {16'h0, s.match[1]};
            TMH_OFS_PR_A:    rd_val = {24'h0, s.pr[0]};
            TMH_OFS_PR_B:    rd_val = {24'h0, s.pr[1]};
            TMH_OFS_TV_A:    rd_val = {16'h0, s.mode[0][TMH_CMR_BIT]
                                       ? h_cap[0] : h_count[0]};
            TMH_OFS_TV_B:    rd_val = {16'h0, s.mode[1][TMH_CMR_BIT]
                                       ? h_cap[1] : h_count[1]};
            default:         rd_ok = 1'b0;
        endcase
    end

    always_comb
    begin
        next_s = s;
        next_s.ilr_wr = 2'b00;
        icr_clr = 16'h0000;
        // write channels, taken in either order
        if (s_axi_awvalid && s.awready)
        begin
            next_s.aw_held = 1'b1;
            next_s.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s.wready)
        begin
            next_s.w_held = 1'b1;
            next_s.wdata = s_axi_wdata;
            next_s.wstrb = s_axi_wstrb;
        end
        if (s.bvalid && s_axi_bready)
        begin
            next_s.bvalid = 1'b0;
        end
        if (s.aw_held && s.w_held && !s.bvalid)
        begin
            next_s.aw_held = 1'b0;
            next_s.w_held = 1'b0;
            next_s.bvalid = 1'b1;
            next_s.bresp = TMH_RESP_OKAY;
            unique case (s.awaddr)
                TMH_OFS_CFG:
                    if (s.wstrb[0]) next_s.cfg = s.wdata[2:0];
                TMH_OFS_MODE_A:
                    if (s.wstrb[0]) next_s.mode[0] = s.wdata[3:0];
                TMH_OFS_MODE_B:
                    if (s.wstrb[0]) next_s.mode[1] = s.wdata[3:0];
                TMH_OFS_CTL:
                    next_s.ctl = (s.ctl & ~wmask[15:0])
                                 | (s.wdata[15:0] & wmask[15:0]);
                TMH_OFS_IMR:
                    next_s.imr = (s.imr & ~wmask[15:0])
                                 | (s.wdata[15:0] & wmask[15:0]);
                TMH_OFS_ICR:
                    icr_clr = s.wdata[15:0] & wmask[15:0];
                TMH_OFS_ILR_A, TMH_OFS_ILR_B:
                begin
                    next_s.ilr[s.awaddr[2]] =
                        (s.ilr[s.awaddr[2]] & ~wmask[15:0])
                        | (s.wdata[15:0] & wmask[15:0]);
                    next_s.ilr_wr[s.awaddr[2]] = 1'b1;
                end
                TMH_OFS_MATCH_A, TMH_OFS_MATCH_B:
                    next_s.match[s.awaddr[2]] =
                        (s.match[s.awaddr[2]] & ~wmask[15:0])
                        | (s.wdata[15:0] & wmask[15:0]);
                TMH_OFS_PR_A, TMH_OFS_PR_B:
                    if (s.wstrb[0]) next_s.pr[s.awaddr[2]] = s.wdata[7:0];
                TMH_OFS_RIS, TMH_OFS_MIS, TMH_OFS_TV_A, TMH_OFS_TV_B:
                    next_s.bresp = TMH_RESP_OKAY;
                default:
                    next_s.bresp = TMH_RESP_SLVERR;
            endcase
        end
        next_s.awready = ~next_s.aw_held;
        next_s.wready = ~next_s.w_held;
        // read channel, one beat in flight
        if (s.rvalid && s_axi_rready)
        begin
            next_s.rvalid = 1'b0;
            next_s.arready = 1'b1;
        end
        if (s_axi_arvalid && s.arready)
        begin
            next_s.rvalid = 1'b1;
            next_s.arready = 1'b0;
            next_s.rdata = rd_val;
            next_s.rresp = rd_ok ? TMH_RESP_OKAY : TMH_RESP_SLVERR;
        end
        // hardware clears of the enable bits follow any software write
        for (int h = 0; h < 2; h++)
        begin
            if (h_en_clr[h])
            begin
                next_s.ctl[h*TMH_CTL_STRIDE+TMH_CTL_EN] = 1'b0;
            end
        end
        // a set in the clearing cycle wins, no event is lost
        next_s.ris = (s.ris & ~icr_clr) | st_set;
        next_s.irq = |(next_s.ris & next_s.imr);
    end

    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            s <= '{cfg: 3'h0, mode: 8'h00, ctl: 16'h0000, imr: 16'h0000,
                   ris: 16'h0000, ilr: {TMH_ILR_RST, TMH_ILR_RST},
                   match: 32'h0000_0000, pr: {TMH_PR_RST, TMH_PR_RST},
                   ilr_wr: 2'b00, irq: 1'b0, awready: 1'b1,
                   aw_held: 1'b0, awaddr: 8'h00, wready: 1'b1,
                   w_held: 1'b0, wdata: 32'h0000_0000, wstrb: 4'h0,
                   bvalid: 1'b0, bresp: TMH_RESP_OKAY, arready: 1'b1,
                   rvalid: 1'b0, rresp: TMH_RESP_OKAY,
                   rdata: 32'h0000_0000};
        end
        else
        begin
            s <= next_s;
        end
    end

    // adc trigger pulses come straight from the half flops
    assign adc_trig      = h_trig;
    assign irq           = s.irq;
    assign s_axi_awready = s.awready;
    assign s_axi_wready  = s.wready;
    assign s_axi_bvalid  = s.bvalid;
    assign s_axi_bresp   = s.bresp;
    assign s_axi_arready = s.arready;
    assign s_axi_rvalid  = s.rvalid;
    assign s_axi_rresp   = s.rresp;
    assign s_axi_rdata   = s.rdata;

endmodule

// File: test/tmh_monitor.sv
// bus handshake and trigger checks for the split timer
// bound to tmh_timer, sees only its ports
`timescale 1ns/100ps
module tmh_monitor
    import tmh_pkg::*;
(
    // clock and reset
    input wire logic        sys_clk,
    input wire logic        resetn,
    // bus
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    // events
    input wire logic [1:0]  adc_trig
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);
    sequence s_wtake;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    property p_wr;
        s_wtake |-> ##2 s_axi_bvalid;
    endproperty
    a_wr: assert property (p_wr) else $error("late write answer");
    property p_wlow;
        s_wtake |=> !s_axi_awready && !s_axi_wready;
    endproperty
    a_wlow: assert property (p_wlow) else $error("ready stayed high");
    property p_rd;
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
    endproperty
    a_rd: assert property (p_rd) else $error("late read answer");
    property p_bdone;
        s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
    endproperty
    a_bdone: assert property (p_bdone) else $error("bvalid stuck");
    property p_rdone;
        s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid;
    endproperty
    a_rdone: assert property (p_rdone) else $error("rvalid stuck");
    property p_arlow;
        s_axi_rvalid |-> !s_axi_arready;
    endproperty
    a_arlow: assert property (p_arlow) else $error("read overlap");
    property p_err;
        s_axi_rvalid && s_axi_rresp == TMH_RESP_SLVERR |-> s_axi_rdata == 0;
    endproperty
    a_err: assert property (p_err) else $error("error data not zero");
    property p_trig;
        adc_trig[0] |=> !adc_trig[0];
    endproperty
    a_trig: assert property (p_trig) else $error("long trigger");
endmodule
bind tmh_timer tmh_monitor tmh_monitor_i(.*);

// File: test/tmh_pin_model.sv
// outside source on the first pin, listener on the second
// assumes the bench calls edges() right after a clock edge
`timescale 1ns/100ps
module tmh_pin_model
(
    // clock
    input wire logic       sys_clk,
    // pins
    input wire logic [1:0] pin_out,
    input wire logic [1:0] pin_oe_n,
    output logic [1:0]     pin_in
);
    logic [1:0] lvl = 2'h0;
    // undriven second line wanders every cycle
    always @(posedge sys_clk) lvl[1] <= ~lvl[1];
    assign pin_in = (pin_oe_n & lvl) | (~pin_oe_n & pin_out);
    task automatic edges(input int n);
        repeat (n)
        begin
            lvl[0] <= ~lvl[0];
            repeat (4) @(posedge sys_clk);
        end
    endtask
endmodule

// File: test/tb.sv
// bench for the split timer over its register bus and pins
// assumes tmh_monitor and tmh_pin_model are compiled first
`timescale 1ns/100ps
module tb
    import tmh_pkg::*;
;
    logic sys_clk = 0, resetn = 0, dbg_halted = 0;
    logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hf;
    // bready and rready stay high: every answer is taken at once
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 1;
    logic s_axi_arvalid = 0, s_axi_rready = 1, irq;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, adc_trig;
    logic [1:0] capture_compare_pin_in, capture_compare_pin_out;
    logic [1:0] capture_compare_pin_oe_n;
    int failures = 0, checked = 0, trigs = 0, n;
    tmh_timer tmh_timer_i(.*);
    tmh_pin_model tmh_pin_model_i(.sys_clk, .pin_out(capture_compare_pin_out),
        .pin_oe_n(capture_compare_pin_oe_n), .pin_in(capture_compare_pin_in));
    always #5 sys_clk = ~sys_clk;
    always @(posedge sys_clk) trigs += adc_trig[0] + adc_trig[1];
    task automatic summarize();
        if (failures == 0 && checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic cmp(input logic [31:0] g, input logic [31:0] e);
        checked++;
        if (g !== e)
        begin
            failures++;
            $display("BAD %0t got %h want %h", $time, g, e);
        end
    endtask
    task automatic wait_tick(inout int k);
        @(posedge sys_clk);
        if (++k > 50)
        begin
            failures++;
            summarize();
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        int k = 0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1;
        s_axi_wvalid <= 1;
        do
        begin
            wait_tick(k);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 0;
        end while (!s_axi_bvalid);
        cmp(s_axi_bresp, TMH_RESP_OKAY);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e,
                      input logic [1:0] r = TMH_RESP_OKAY);
        int k = 0;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1;
        do
        begin
            wait_tick(k);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 0;
        end while (!s_axi_rvalid);
        cmp(s_axi_rdata, e);
        cmp(s_axi_rresp, r);
    endtask
    initial
    begin
        repeat (4) @(posedge sys_clk);
        resetn <= 1;
        @(posedge sys_clk);
        rd(TMH_OFS_ILR_A, 32'hffff);
        rd(8'h40, 0, TMH_RESP_SLVERR);
        wr(TMH_OFS_CFG, 4);
        wr(TMH_OFS_MODE_A, 1);
        wr(TMH_OFS_PR_A, 1);
        wr(TMH_OFS_ILR_A, 3);
        wr(TMH_OFS_IMR, 1);
        wr(TMH_OFS_CTL, 32'h21);
        // prescale 1 doubles the run to time-out, eight clocks
        repeat (5) @(posedge sys_clk);
        rd(TMH_OFS_RIS, 0);
        repeat (9) @(posedge sys_clk);
        rd(TMH_OFS_RIS, 1);
        rd(TMH_OFS_MIS, 1);
        cmp(irq, 1);
        rd(TMH_OFS_CTL, 32'h20);
        cmp(trigs, 1);
        wr(TMH_OFS_ICR, 1);
        rd(TMH_OFS_RIS, 0);
        cmp(irq, 0);
        // edge count, both edges, four counted of six
        wr(TMH_OFS_MODE_A, 3);
        wr(TMH_OFS_ILR_A, 32'ha);
        wr(TMH_OFS_MATCH_A, 6);
        wr(TMH_OFS_CTL, 32'h0d);
        tmh_pin_model_i.edges(6);
        repeat (8) @(posedge sys_clk);
        rd(TMH_OFS_RIS, 2);
        rd(TMH_OFS_CTL, 32'h0c);
        rd(TMH_OFS_TV_A, 32'ha);
        // edge time, rising: one step per clock, edge acts 4 clocks later
        wr(TMH_OFS_MODE_A, 7);
        wr(TMH_OFS_ILR_A, 32'hffff);
        wr(TMH_OFS_CTL, 1);
        tmh_pin_model_i.edges(1);
        rd(TMH_OFS_TV_A, 32'hfffb);
        rd(TMH_OFS_RIS, 6);
        // pwm on second half: period 10, high 6, held first by stall
        wr(TMH_OFS_MODE_B, 32'ha);
        wr(TMH_OFS_ILR_B, 9);
        wr(TMH_OFS_MATCH_B, 3);
        dbg_halted <= 1;
        wr(TMH_OFS_CTL, 32'h30c);
        repeat (5) @(posedge sys_clk);
        rd(TMH_OFS_TV_B, 9);
        dbg_halted <= 0;
        repeat (30) @(posedge sys_clk);
        n = 0;
        repeat (20) @(posedge sys_clk) n += capture_compare_pin_out[1];
        cmp(n, 12);
        cmp(capture_compare_pin_oe_n[1], 0);
        cmp({capture_compare_pin_out[0],
             capture_compare_pin_oe_n[0]}, 1);
        rd(TMH_OFS_RIS, 6);
        // first half periodic without trigger, second half inverted
        wr(TMH_OFS_MODE_A, 2);
        wr(TMH_OFS_ILR_A, 3);
        wr(TMH_OFS_CTL, 32'h4101);
        n = 0;
        repeat (20) @(posedge sys_clk) n += capture_compare_pin_out[1];
        cmp(n, 8);
        rd(TMH_OFS_CTL, 32'h4101);
        rd(TMH_OFS_RIS, 7);
        cmp(trigs, 1);
        summarize();
    end
endmodule
